// >>> logic/stcf_regs.svh
// Register map, field positions, reset values and segment counts of the transmit framer
`ifndef STCF_REGS_SVH
`define STCF_REGS_SVH
`define STCF_CTRL_OFF   8'h00
`define STCF_CFG_OFF    8'h04
`define STCF_STAT_OFF   8'h08
`define STCF_EN_BIT     0
`define STCF_CRI_LSB    1
`define STCF_FSEL_LSB   4
`define STCF_NSF_LSB    0
`define STCF_NPM_LSB    8
`define STCF_CTRL_RST   32'h0000_0000
`define STCF_CFG_RST    32'h0000_0204
`define STCF_PN_SEED    20'h0_0001
`define STCF_CRC_POLY   32'h8141_41ab
`define STCF_DATA_BITS  13'd5984
`define STCF_BLK_BITS   13'd6016
`define STCF_CW0        15'd6600
`define STCF_CW1        15'd7260
`define STCF_CW2        15'd7920
`define STCF_CW3        15'd10560
`define STCF_CW4        15'd15840
`define STCF_CW5        15'd21120
`define STCF_CW6        15'd31680
`define STCF_PRE_LEN    12'd768
`define STCF_FAMB0_LEN  12'd544
`define STCF_FAMB1_LEN  12'd1056
`define STCF_FAMB2_LEN  12'd2080
`define STCF_PAMB_LEN   12'd166
`define STCF_DSEG_LEN   12'd660
`define STCF_EOT_LEN    12'd768
`endif

// >>> logic/stcf_pkg.sv
// Types shared by the transmit framer
package stcf_pkg;
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_PRE   = 3'b001,
      ST_FREQ  = 3'b010,
      ST_DATA  = 3'b011,
      ST_PHASE = 3'b100,
      ST_EOT   = 3'b101
   } stcf_state_t;
   typedef enum logic [1:0] {
      SEL_PRE   = 2'h0,
      SEL_FREQ  = 2'h1,
      SEL_PHASE = 2'h2,
      SEL_DATA  = 2'h3
   } stcf_sel_t;
endpackage

// >>> logic/stcf_top.sv
// Scrambler, CRC, dual coder, OQPSK mapper, symbol FIFO and frame assembly with APB registers
// Operation
// - Scramble each data bit with an own x^20+x^17+1 PN generator.
// - The PN generator advances one bit per accepted data bit.
// - Append a 32-bit CRC so each coder block holds 6016 bits.
// - CRC generator is the given degree-32 polynomial.
// - Successive blocks go alternately to the two coders.
// - Coder outputs are sequenced and never overlap.
// - Codeword length follows coding-rate index 0..6.
// - Coded bits are paired onto OQPSK and each bit held two samples.
// - Quadrature bit lags in-phase bit by one oversampled sample.
// - Every modulated sample is written to the symbol FIFO.
// - Framer reads FIFO with a read enable when symbols are available.
// - Frequency midamble lasts 544, 1056 or 2080 samples by selection.
// - Phase midambles per subframe come from a configured count.
// - Preamble lasts 768 samples, 256 AGC then 512 timing.
// - Each phase midamble lasts 166 samples.
// - Framer pulses a fetch of the coding-rate index per subframe.
// - Framer pulses subframe increment once per subframe, wrapping at count.
// - Framer raises the EOT flag to produce an EOT frame.
// - Framer selects preamble, frequency, phase or data for shaping.
// - Software drives transmit enable; device derives the end-of-enable flag.
// - Framer state is visible on a debug output.
// - Transmit enable is resampled only while the subframe counter is 0.
//
// The APB interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
`include "stcf_regs.svh"
module stcf_top
   import stcf_pkg::*;
#(
   parameter int FIFO_DEPTH = 16,
   parameter int FIFO_AW    = 4
)(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        pclk_en,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        src_bit,
   input  wire logic        src_valid,
   output logic             src_ready,
   output logic      [1:0]  tx_select,
   output logic             preamble_en,
   output logic             freq_midamble_en,
   output logic             phase_midamble_en,
   output logic             data_en,
   output logic             sym_i,
   output logic             sym_q,
   output logic             pop_cri,
   output logic      [2:0]  cri_used,
   output logic             inc_subframe_cnt,
   output logic             eot_flag_out,
   output logic      [2:0]  fsm_state
);
////////////////////////////////////////////////////////////////////////////////
   logic [31:0] ctrl_ff, cfg_ff, prdata_ff, rd_mux;
   logic        pready_ff, pslverr_ff, hit;
   logic [7:0]  nsf, npm;
   logic [2:0]  cri;
   logic [1:0]  fsel;
   logic [FIFO_AW:0] fifo_cnt_ff;
   logic [7:0]  sf_cnt_ff;
   logic        en_s_ff;
   stcf_state_t state_ff, nxt_state;

   assign cri  = ctrl_ff[`STCF_CRI_LSB +: 3];
   assign fsel = ctrl_ff[`STCF_FSEL_LSB +: 2];
   assign nsf  = cfg_ff[`STCF_NSF_LSB +: 8];
   assign npm  = cfg_ff[`STCF_NPM_LSB +: 8];

   always_comb
   begin
      hit    = 1'b1;
      rd_mux = 32'h0000_0000;
      case (paddr)
         `STCF_CTRL_OFF: rd_mux = ctrl_ff;
         `STCF_CFG_OFF:  rd_mux = cfg_ff;
         `STCF_STAT_OFF: rd_mux = {en_s_ff, 7'h00, 3'h0, fifo_cnt_ff, sf_cnt_ff, 5'h00, state_ff};
         default:        hit = 1'b0;
      endcase
   end

   // APB: one-cycle access phase, unmapped addresses answer with pslverr
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff  <= 32'h0000_0000;
      end
      else if (pclk_en)
      begin
         pready_ff  <= psel & ~penable;
         pslverr_ff <= psel & ~penable & ~hit;
         if (psel & ~penable & ~pwrite)
            prdata_ff <= rd_mux;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_ff <= `STCF_CTRL_RST;
         cfg_ff  <= `STCF_CFG_RST;
      end
      else if (pclk_en && psel && penable && pready_ff && pwrite)
      begin
         if (paddr == `STCF_CTRL_OFF)
            ctrl_ff <= pwdata;
         if (paddr == `STCF_CFG_OFF)
            cfg_ff <= pwdata;
      end
   end
////////////////////////////////////////////////////////////////////////////////
   // Scrambler and CRC fill into the two coder buffers
   logic [6015:0] cmem [2];
   logic [19:0] pn_ff;
   logic [31:0] crc_ff;
   logic [12:0] fill_cnt_ff, nxt_fill;
   logic [1:0]  full_ff, nxt_full;
   logic        wr_sel_ff, nxt_wr_sel, src_ready_ff;
   logic        take, crc_step, wen, wbit, last, set_full, pn_bit, scr_bit, clr_full;
   logic        rd_sel_ff;

   always_comb
   begin
      pn_bit   = pn_ff[19] ^ pn_ff[16];
      scr_bit  = src_bit ^ pn_bit;
      take     = src_valid & src_ready_ff;
      crc_step = (fill_cnt_ff >= `STCF_DATA_BITS) & ~full_ff[wr_sel_ff];
      wen      = take | crc_step;
      wbit     = take ? scr_bit : crc_ff[31];
      last     = fill_cnt_ff == `STCF_BLK_BITS - 13'd1;
      set_full = wen & last;
      nxt_fill   = wen ? (last ? 13'd0 : fill_cnt_ff + 13'd1) : fill_cnt_ff;
      nxt_wr_sel = set_full ? ~wr_sel_ff : wr_sel_ff;
      nxt_full   = full_ff;
      if (set_full)
         nxt_full[wr_sel_ff] = 1'b1;
      if (clr_full)
         nxt_full[rd_sel_ff] = 1'b0;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pn_ff        <= `STCF_PN_SEED;
         crc_ff       <= 32'h0000_0000;
         fill_cnt_ff  <= 13'd0;
         wr_sel_ff    <= 1'b0;
         full_ff      <= 2'b00;
         src_ready_ff <= 1'b0;
      end
      else if (pclk_en)
      begin
         if (take)
            pn_ff <= {pn_ff[18:0], pn_bit};
         if (take)
            crc_ff <= {crc_ff[30:0], 1'b0} ^ ((scr_bit ^ crc_ff[31]) ? `STCF_CRC_POLY : 32'h0000_0000);
         else if (crc_step)
            crc_ff <= last ? 32'h0000_0000 : {crc_ff[30:0], 1'b0};
         fill_cnt_ff  <= nxt_fill;
         wr_sel_ff    <= nxt_wr_sel;
         full_ff      <= nxt_full;
         src_ready_ff <= (nxt_fill < `STCF_DATA_BITS) & ~nxt_full[nxt_wr_sel];
      end
   end

   always_ff @(posedge pclk)
   begin
      if (pclk_en && wen)
         cmem[wr_sel_ff][fill_cnt_ff] <= wbit;
   end
////////////////////////////////////////////////////////////////////////////////
   // Coder output sequencer and OQPSK mapper
   logic [14:0] out_cnt_ff, cw_len_ff, cw_len;
   logic [12:0] idx_ff;
   logic        busy_ff, par_ff, ph_ff, i_ff, q_ff, emit, start, cbit, mbit;
   logic [1:0]  fifo_wdata;

   always_comb
   begin
      case (cri)
         3'd0:    cw_len = `STCF_CW0;
         3'd1:    cw_len = `STCF_CW1;
         3'd2:    cw_len = `STCF_CW2;
         3'd3:    cw_len = `STCF_CW3;
         3'd4:    cw_len = `STCF_CW4;
         3'd5:    cw_len = `STCF_CW5;
         default: cw_len = `STCF_CW6;
      endcase
   end

   assign start      = ~busy_ff & full_ff[rd_sel_ff];
   assign emit       = busy_ff & (fifo_cnt_ff < (FIFO_AW+1)'(FIFO_DEPTH - 2));
   assign mbit       = cmem[rd_sel_ff][idx_ff];
   assign cbit       = (out_cnt_ff >= {2'b00, `STCF_BLK_BITS}) ? mbit ^ par_ff : mbit;
   assign clr_full   = emit & (out_cnt_ff == cw_len_ff - 15'd1);
   assign fifo_wdata = ph_ff ? {i_ff, cbit} : {cbit, q_ff};

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         busy_ff    <= 1'b0;
         rd_sel_ff  <= 1'b0;
         out_cnt_ff <= 15'd0;
         idx_ff     <= 13'd0;
         cw_len_ff  <= `STCF_CW0;
         par_ff     <= 1'b0;
         ph_ff      <= 1'b0;
         i_ff       <= 1'b0;
         q_ff       <= 1'b0;
      end
      else if (pclk_en)
      begin
         if (start)
         begin
            busy_ff    <= 1'b1;
            cw_len_ff  <= cw_len;
            out_cnt_ff <= 15'd0;
            idx_ff     <= 13'd0;
            par_ff     <= 1'b0;
            ph_ff      <= 1'b0;
         end
         else if (emit)
         begin
            out_cnt_ff <= out_cnt_ff + 15'd1;
            idx_ff     <= (idx_ff == `STCF_BLK_BITS - 13'd1) ? 13'd0 : idx_ff + 13'd1;
            par_ff     <= par_ff ^ mbit;
            ph_ff      <= ~ph_ff;
            if (ph_ff)
               q_ff <= cbit;
            else
               i_ff <= cbit;
            if (clr_full)
            begin
               busy_ff   <= 1'b0;
               rd_sel_ff <= ~rd_sel_ff;
            end
         end
      end
   end
////////////////////////////////////////////////////////////////////////////////
   // Symbol FIFO
   logic [1:0]         fifo_mem [FIFO_DEPTH];
   logic [FIFO_AW-1:0] wp_ff, rp_ff;
   logic               pop, sym_i_ff, sym_q_ff, data_en_ff;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         wp_ff       <= '0;
         rp_ff       <= '0;
         fifo_cnt_ff <= '0;
         sym_i_ff    <= 1'b0;
         sym_q_ff    <= 1'b0;
         data_en_ff  <= 1'b0;
      end
      else if (pclk_en)
      begin
         if (emit)
            wp_ff <= wp_ff + FIFO_AW'(1);
         if (pop)
         begin
            rp_ff    <= rp_ff + FIFO_AW'(1);
            sym_i_ff <= fifo_mem[rp_ff][1];
            sym_q_ff <= fifo_mem[rp_ff][0];
         end
         data_en_ff  <= pop;
         fifo_cnt_ff <= fifo_cnt_ff + {{FIFO_AW{1'b0}}, emit} - {{FIFO_AW{1'b0}}, pop};
      end
   end

   always_ff @(posedge pclk)
   begin
      if (pclk_en && emit)
         fifo_mem[wp_ff] <= fifo_wdata;
   end
////////////////////////////////////////////////////////////////////////////////
   // Frame assembly
   logic [11:0] seg_cnt_ff, flen;
   logic [7:0]  seg_idx_ff;
   logic        en_now, end_now, tx_end_ff, seg_last, sf_last, pop_cri_ff, inc_ff, eot_ff;
   logic [2:0]  cri_used_ff;
   logic [1:0]  sel_ff;
   logic        pre_ff, freq_ff, phase_ff;

   assign en_now  = (sf_cnt_ff == 8'd0) ? ctrl_ff[`STCF_EN_BIT] : en_s_ff;
   assign end_now = en_s_ff & ~en_now;
   assign flen    = (fsel == 2'd0) ? `STCF_FAMB0_LEN : (fsel == 2'd1) ? `STCF_FAMB1_LEN : `STCF_FAMB2_LEN;
   assign pop     = (state_ff == ST_DATA) && (fifo_cnt_ff != '0);
   assign sf_last = ({1'b0, sf_cnt_ff} + 9'd1) >= {1'b0, nsf};

   always_comb
   begin
      nxt_state = state_ff;
      seg_last  = 1'b0;
      case (state_ff)
         ST_IDLE:
         begin
            if (tx_end_ff | end_now)
               nxt_state = ST_EOT;
            else if (en_now)
               nxt_state = ST_PRE;
         end
         ST_PRE:
         begin
            seg_last = seg_cnt_ff == `STCF_PRE_LEN - 12'd1;
            if (seg_last)
               nxt_state = ST_FREQ;
         end
         ST_FREQ:
         begin
            seg_last = seg_cnt_ff == flen - 12'd1;
            if (seg_last)
               nxt_state = ST_DATA;
         end
         ST_DATA:
         begin
            seg_last = pop && (seg_cnt_ff == `STCF_DSEG_LEN - 12'd1);
            if (seg_last)
               nxt_state = (seg_idx_ff < npm) ? ST_PHASE : (sf_last ? ST_IDLE : ST_FREQ);
         end
         ST_PHASE:
         begin
            seg_last = seg_cnt_ff == `STCF_PAMB_LEN - 12'd1;
            if (seg_last)
               nxt_state = ST_DATA;
         end
         ST_EOT:
         begin
            seg_last = seg_cnt_ff == `STCF_EOT_LEN - 12'd1;
            if (seg_last)
               nxt_state = ST_IDLE;
         end
         default: nxt_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_ff   <= ST_IDLE;
         seg_cnt_ff <= 12'd0;
         seg_idx_ff <= 8'd0;
         sf_cnt_ff  <= 8'd0;
         en_s_ff    <= 1'b0;
         tx_end_ff  <= 1'b0;
      end
      else if (pclk_en)
      begin
         state_ff <= nxt_state;
         en_s_ff  <= en_now;
         if (end_now)
            tx_end_ff <= 1'b1;
         else if (state_ff == ST_EOT)
            tx_end_ff <= 1'b0;
         if (seg_last || state_ff == ST_IDLE)
            seg_cnt_ff <= 12'd0;
         else if (state_ff != ST_DATA || pop)
            seg_cnt_ff <= seg_cnt_ff + 12'd1;
         if (state_ff == ST_FREQ)
            seg_idx_ff <= 8'd0;
         else if (state_ff == ST_PHASE && seg_last)
            seg_idx_ff <= seg_idx_ff + 8'd1;
         if (state_ff == ST_DATA && seg_last && nxt_state != ST_PHASE)
            sf_cnt_ff <= sf_last ? 8'd0 : sf_cnt_ff + 8'd1;
      end
   end

   // Strobes except pop_cri follow the state by one cycle, in step with data_en, which lags its pop
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sel_ff      <= SEL_PRE;
         pre_ff      <= 1'b0;
         freq_ff     <= 1'b0;
         phase_ff    <= 1'b0;
         eot_ff      <= 1'b0;
         pop_cri_ff  <= 1'b0;
         inc_ff      <= 1'b0;
         cri_used_ff <= 3'd0;
      end
      else if (pclk_en)
      begin
         case (state_ff)
            ST_FREQ:  sel_ff <= SEL_FREQ;
            ST_PHASE: sel_ff <= SEL_PHASE;
            ST_DATA:  sel_ff <= SEL_DATA;
            default:  sel_ff <= SEL_PRE;
         endcase
         pre_ff     <= state_ff == ST_PRE || state_ff == ST_EOT;
         freq_ff    <= state_ff == ST_FREQ;
         phase_ff   <= state_ff == ST_PHASE;
         eot_ff     <= state_ff == ST_EOT;
         pop_cri_ff <= nxt_state == ST_FREQ && state_ff != ST_FREQ;
         inc_ff     <= state_ff == ST_DATA && seg_last && nxt_state != ST_PHASE;
         if (nxt_state == ST_FREQ && state_ff != ST_FREQ)
            cri_used_ff <= cri;
      end
   end

   assign prdata            = prdata_ff;
   assign pready            = pready_ff;
   assign pslverr           = pslverr_ff;
   assign src_ready         = src_ready_ff;
   assign tx_select         = sel_ff;
   assign preamble_en       = pre_ff;
   assign freq_midamble_en  = freq_ff;
   assign phase_midamble_en = phase_ff;
   assign data_en           = data_en_ff;
   assign sym_i             = sym_i_ff;
   assign sym_q             = sym_q_ff;
   assign pop_cri           = pop_cri_ff;
   assign cri_used          = cri_used_ff;
   assign inc_subframe_cnt  = inc_ff;
   assign eot_flag_out      = eot_ff;
   assign fsm_state         = state_ff;
////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn || !pclk_en);

   sequence even_emit_s; emit && !ph_ff; endsequence
   sequence odd_emit_s; emit && ph_ff; endsequence

   pn_hold_a: assert property (!take |=> $stable(pn_ff)) else $error("PN moved without data");
   blk_len_a: assert property (set_full |-> fill_cnt_ff == 13'd6015 && !take) else $error("Block not 6016");
   slot_sep_a: assert property (wen |-> !(busy_ff && wr_sel_ff == rd_sel_ff)) else $error("Slot clash");
   busy_full_a: assert property (busy_ff |-> full_ff[rd_sel_ff]) else $error("Output overlap");
   i_hold_a: assert property (even_emit_s ##1 odd_emit_s |-> fifo_wdata[1] == $past(fifo_wdata[1]))
      else $error("I not held");
   q_lag_a: assert property (odd_emit_s ##1 even_emit_s |-> fifo_wdata[0] == $past(fifo_wdata[0]))
      else $error("Q not lagged");
   fifo_rd_a: assert property (data_en_ff |-> $past(fifo_cnt_ff) != '0) else $error("Read of empty FIFO");
   pre_len_a: assert property (state_ff == ST_PRE && seg_cnt_ff == 12'd767 |=> state_ff == ST_FREQ && pop_cri_ff)
      else $error("Preamble length");
   freq_len_a: assert property (state_ff == ST_FREQ |-> seg_cnt_ff < flen) else $error("Midamble overrun");
   phase_len_a: assert property (state_ff == ST_PHASE && seg_cnt_ff == 12'd165 |=> state_ff == ST_DATA)
      else $error("Phase midamble length");
   inc_pulse_a: assert property (inc_ff |=> !inc_ff) else $error("Increment not a pulse");
   en_sample_a: assert property (sf_cnt_ff != 8'd0 |=> $stable(en_s_ff)) else $error("Enable resampled");
   eot_flag_a: assert property (state_ff == ST_EOT |=> eot_ff) else $error("EOT flag missing");
endmodule

// >>> test/stcf_src_model.sv
// Upstream bit source model that feeds the scrambler input one bit at a time
`timescale 1ns/1ps
module stcf_src_model (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic pclk_en,
   input  wire logic src_ready,
   output logic      src_bit,
   output logic      src_valid
);
   integer seed = 82;
   // A bit is held until taken; while idle the data line toggles so a stale value cannot pass
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         src_valid <= 1'b0;
         src_bit   <= 1'b0;
      end
      else if (pclk_en && (!src_valid || src_ready))
      begin
         src_valid <= (($random(seed) & 7) != 0);
         src_bit   <= src_valid ? 1'($random(seed)) : ~src_bit;
      end
   end
endmodule

// >>> test/tb_top.sv
// Self-checking bench for the transmit framer: registers, frame layout and coded data
`timescale 1ns/1ps
module tb_top;
   import stcf_pkg::*;
   logic        pclk    = 1'b0;
   logic        presetn = 1'b0;
   logic        pclk_en = 1'b1;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [7:0]  paddr   = 8'h00;
   logic [31:0] pwdata  = 32'h0;
   logic [31:0] prdata, r, crc, crc_seen;
   logic        pready, pslverr, e, src_bit, src_valid, src_ready;
   logic [1:0]  tx_select, cur_sel, fs;
   logic        preamble_en, freq_midamble_en, phase_midamble_en, data_en, sym_i, sym_q;
   logic        pop_cri, inc_subframe_cnt, eot_flag_out, fb, nz;
   logic [2:0]  cri_used, fsm_state, cri;
   logic        s    [0:6015];
   logic        pn   [0:5983];
   logic        in_q [$];
   logic [1:0]  iq_q [$];
   logic [31:0] seg_q [$];
   int          bad_count = 0;
   int          n_tests = 0;
   int          cur_code = 7;
   int          cur_len, code, n_pop, n_inc, k, flen, e1, e2, e3, ec;
   logic        cri_chk = 1'b0;
   int          seg_code [10] = '{0, 1, 3, 2, 3, 1, 3, 2, 3, 4};
   int          seg_len  [5]  = '{768, 0, 166, 660, 768};

   always #2.5 pclk = ~pclk;

   stcf_top #(.FIFO_DEPTH(16), .FIFO_AW(4)) stcf_top_inst (
      .pclk(pclk), .presetn(presetn), .pclk_en(pclk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .src_bit(src_bit), .src_valid(src_valid), .src_ready(src_ready), .tx_select(tx_select),
      .preamble_en(preamble_en), .freq_midamble_en(freq_midamble_en), .phase_midamble_en(phase_midamble_en),
      .data_en(data_en), .sym_i(sym_i), .sym_q(sym_q), .pop_cri(pop_cri), .cri_used(cri_used),
      .inc_subframe_cnt(inc_subframe_cnt), .eot_flag_out(eot_flag_out), .fsm_state(fsm_state));

   stcf_src_model stcf_src_model_inst (
      .pclk(pclk), .presetn(presetn), .pclk_en(pclk_en), .src_ready(src_ready), .src_bit(src_bit),
      .src_valid(src_valid));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic summarize();
      $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50)
         bad_count++;
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Segment recorder: one entry per segment with select, kind and length
   always @(posedge pclk)
   begin
      if (presetn === 1'b1)
      begin
         code = eot_flag_out ? 4 : preamble_en ? 0 : freq_midamble_en ? 1 : phase_midamble_en ? 2 :
                (tx_select === SEL_DATA) ? 3 : 7;
         if (code != cur_code)
         begin
            if (cur_code != 7)
               seg_q.push_back({6'h0, cur_sel, 8'(cur_code), 16'(cur_len)});
            cur_code = code;
            cur_sel  = tx_select;
            cur_len  = 0;
         end
         cur_len += (code == 3) ? int'(data_en === 1'b1) : int'(code != 7);
         if (cri_chk)
            check({29'h0, cri_used}, {29'h0, cri});
         cri_chk = (pop_cri === 1'b1);
         n_pop += int'(pop_cri === 1'b1);
         n_inc += int'(inc_subframe_cnt === 1'b1);
         if (data_en === 1'b1 && iq_q.size() < 6016)
            iq_q.push_back({sym_i, sym_q});
         if (src_valid === 1'b1 && src_ready === 1'b1 && pclk_en === 1'b1 && in_q.size() < 5984)
            in_q.push_back(src_bit);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 8'h00, 32'h0);
      check(r, 32'h0);
      apb(1'b0, 8'h04, 32'h0);
      check(r, 32'h0000_0204);
      apb(1'b0, 8'h08, 32'h0);
      check(r & 32'h8000_ff07, 32'h0);
      apb(1'b1, 8'h0c, 32'hffff_ffff);
      check({31'h0, e}, 32'h1);
      apb(1'b0, 8'h0c, 32'h0);
      check({e, r[30:0]}, 32'h8000_0000);
      apb(1'b0, 8'h00, 32'h0);
      check(r, 32'h0);
      $display("test registers done");
      // Freeze the whole design for eight edges; the coded-data checks show nothing slipped
      pclk_en <= 1'b0;
      repeat (8) @(posedge pclk);
      pclk_en <= 1'b1;
      for (int f = 0; f < 3; f++)
      begin
         fs   = (f == 2) ? 2'd3 : 2'(f);
         cri  = 3'(3 * f);
         flen = (fs == 0) ? 544 : (fs == 1) ? 1056 : 2080;
         apb(1'b1, 8'h04, 32'h0000_0102);
         apb(1'b1, 8'h00, {26'h0, fs, cri, 1'b1});
         k = 0;
         while (n_inc < 2 * f + 1 && k < 40000)
         begin
            @(posedge pclk);
            k++;
         end
         apb(1'b1, 8'h00, {26'h0, fs, cri, 1'b0});
         apb(1'b0, 8'h08, 32'h0);
         check({r[31], 15'h0, r[15:8]}, 32'h0080_0001);
         while ((fsm_state !== ST_IDLE || eot_flag_out !== 1'b0 || seg_q.size() < 10) && k < 80000)
         begin
            @(posedge pclk);
            k++;
         end
         check(32'(k < 80000), 32'h1);
         repeat (3) @(posedge pclk);
         check(32'(n_pop), 32'(2 * f + 2));
         check(32'(n_inc), 32'(2 * f + 2));
         apb(1'b0, 8'h08, 32'h0);
         check(r & 32'h8000_ff07, 32'h0);
         for (int i = 0; i < 10; i++)
         begin
            ec = seg_code[i];
            check((seg_q.size() > 0) ? seg_q.pop_front() : 32'hffff_ffff, {6'h0, 2'((ec == 4) ? 0 : ec),
                  8'(ec), 16'((ec == 1) ? flen : seg_len[ec])});
         end
         $display("test frame %0d done", f);
      end
      check(32'(iq_q.size()), 32'd6016);
      e1 = 0;
      e2 = 0;
      e3 = 0;
      nz = 1'b0;
      crc = 32'h0;
      for (int n = 0; n < 6016; n++)
         s[n] = iq_q[n][!n[0]];
      for (int n = 0; n < 6015; n++)
         e3 += int'(iq_q[n + 1][!n[0]] !== iq_q[n][!n[0]]);
      for (int n = 0; n < 5984; n++)
      begin
         pn[n] = s[n] ^ in_q[n];
         nz |= pn[n];
         if (n >= 20)
         begin
            e1 += int'(pn[n] !== (pn[n - 3] ^ pn[n - 20]));
            e2 += int'(pn[n] !== (pn[n - 17] ^ pn[n - 20]));
         end
         fb = crc[31] ^ s[n];
         crc = {crc[30:0], 1'b0} ^ (fb ? 32'h8141_41ab : 32'h0);
      end
      for (int n = 5984; n < 6016; n++)
         crc_seen = {crc_seen[30:0], s[n]};
      check({31'h0, nz && (e1 == 0 || e2 == 0)}, 32'h1);
      check(crc_seen, crc);
      check(32'(e3), 32'h0);
      $display("test coded data done");
      summarize();
   end

   initial
   begin
      repeat (90000) @(posedge pclk);
      bad_count++;
      summarize();
   end
endmodule
